// >>> rtl/pit_params.svh
// Address map, field positions, reset values and prescaler limits of the periodic timer.
// Assumes an 8-bit register port whose addresses are the printed offsets.
`ifndef PIT_PARAMS_SVH
`define PIT_PARAMS_SVH

`define PIT_ADDR_STATUS   8'h4b
`define PIT_ADDR_CNT_HI   8'h4c
`define PIT_ADDR_CNT_LO   8'h4d
`define PIT_ADDR_MOD_HI   8'h4e
`define PIT_ADDR_MOD_LO   8'h4f

`define PIT_BIT_FLAG      7
`define PIT_BIT_IRQ_EN    6
`define PIT_BIT_HALT      5
`define PIT_BIT_CLEAR     4
`define PIT_PS_MSB        2
`define PIT_PS_LSB        0

`define PIT_RST_MODULO    16'hffff
`define PIT_RST_COUNT     16'h0000
`define PIT_RST_HALT      1'b1
`define PIT_RST_PS        3'h0
`define PIT_PRE_WIDTH     6
`define PIT_PRE_MAX_CODE  3'h6

`endif

// >>> rtl/pit_pkg.sv
// Types shared by the periodic timer and its prescaler.
// Assumes nothing beyond a SystemVerilog compiler.
package pit_pkg;

   typedef logic [15:0] pit_count_t;
   typedef logic [7:0]  pit_byte_t;

   typedef enum logic [2:0] {
      PIT_DIV1  = 3'h0,
      PIT_DIV2  = 3'h1,
      PIT_DIV4  = 3'h2,
      PIT_DIV8  = 3'h3,
      PIT_DIV16 = 3'h4,
      PIT_DIV32 = 3'h5,
      PIT_DIV64 = 3'h6,
      PIT_DIV64B = 3'h7
   } pit_prescale_t;

endpackage

// >>> rtl/pit_prescaler.sv
// Bus clock prescaler for the periodic timer: one-cycle tick enable at the selected rate.
// Assumes run and clear come from the timer core on the same clock.
`timescale 1ns/100ps
`include "pit_params.svh"

module pit_prescaler #(
   parameter int PRE_W = `PIT_PRE_WIDTH
) (
   // Clock and reset
   input  wire logic                   REF_CLK,
   input  wire logic                   NRST,
   // Control
   input  wire logic                   run,
   input  wire logic                   clear,
   input  wire pit_pkg::pit_prescale_t sel,
   // Rate enable
   output logic                        tick
);

   logic [PRE_W-1:0] pre_r;
   logic [PRE_W-1:0] pre_nxt;
   wire  [2:0]       sel_lim;
   wire  [PRE_W-1:0] mask;

   assign sel_lim = (sel > `PIT_PRE_MAX_CODE) ? `PIT_PRE_MAX_CODE : sel;
   assign mask    = PRE_W'((7'h01 << sel_lim) - 7'h01);

   // The tick is taken from the low bits all being one, so a rate change never waits a full wrap.
   assign tick    = run & ~clear & ((pre_r & mask) == mask);

   assign pre_nxt = clear ? '0 : (run ? PRE_W'(pre_r + 1'b1) : pre_r);

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         pre_r <= '0;
      end else begin
         pre_r <= pre_nxt;
      end
   end

endmodule

// >>> rtl/pit_timer.sv
// Periodic interrupt timer: 16-bit modulo up-counter, prescaler, status/control and register port.
// Assumes a single-master byte register port and break/stop levels synchronous to REF_CLK.
//
// Contract
// - Counter holds while the system is in break.
// - With break-clear permitted, status clears in break persist after it.
// - Without permit, break accesses leave the flag and its arm alone; armed clear completes later.
// - Overflow flag sets when the counter steps from the modulo value back to zero.
// - Overflow during the clear sequence keeps the flag; writing one does nothing.
// - Interrupt enable gates the flag onto the request; reset clears both.
// - Halt bit stops counting, clearing it resumes; reset sets it.
// - Counter-clear write resets counter and prescaler, self-clears, reads zero.
// - Halt and counter-clear together leave the counter stopped at zero.
// - Prescale select gives divide 1 to 64; code 111 also divides by 64.
// - High-byte read latches low byte until the low byte is read.
// - Reset and counter-clear both zero the counter registers.
// - After reaching modulo the counter restarts at zero next timer clock.
// - Modulo high write blocks flag and interrupt until modulo low write.
// - Reset sets both modulo registers to all ones.
// - Counter is 16 bits, free-running or modulo; reads never disturb it.
// - In stop mode the timer idles and keeps its state.
`timescale 1ns/100ps
`include "pit_params.svh"

module pit_timer #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input  wire logic       REF_CLK,
   input  wire logic       NRST,
   // Register port
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   // System state
   input  wire logic       BREAK,
   input  wire logic       BREAK_CLEAR_PERMIT,
   input  wire logic       STOP_MODE,
   // Interrupt request
   output logic            IRQ
);

   // State
   pit_pkg::pit_count_t    count_r;
   pit_pkg::pit_count_t    count_nxt;
   pit_pkg::pit_byte_t     mod_hi_r;
   pit_pkg::pit_byte_t     mod_lo_r;
   pit_pkg::pit_byte_t     low_latch_r;
   pit_pkg::pit_byte_t     rdata_r;
   pit_pkg::pit_byte_t     rdata_nxt;
   pit_pkg::pit_prescale_t ps_r;
   logic                   flag_r;
   logic                   flag_nxt;
   logic                   arm_r;
   logic                   arm_nxt;
   logic                   irq_en_r;
   logic                   halt_r;
   logic                   mod_inhibit_r;
   logic                   latched_r;
   logic                   tick;

   // Address decode
   wire sel_status  = (ADDR == `PIT_ADDR_STATUS);
   wire sel_cnt_hi  = (ADDR == `PIT_ADDR_CNT_HI);
   wire sel_cnt_lo  = (ADDR == `PIT_ADDR_CNT_LO);
   wire sel_mod_hi  = (ADDR == `PIT_ADDR_MOD_HI);
   wire sel_mod_lo  = (ADDR == `PIT_ADDR_MOD_LO);
   wire wr_status   = WR & sel_status;
   wire wr_mod_hi   = WR & sel_mod_hi;
   wire wr_mod_lo   = WR & sel_mod_lo;
   wire rd_status   = RD & sel_status;
   wire rd_cnt_hi   = RD & sel_cnt_hi;
   wire rd_cnt_lo   = RD & sel_cnt_lo;

   wire brk_protect = BREAK & ~BREAK_CLEAR_PERMIT;

   wire cnt_clear   = wr_status & WDATA[`PIT_BIT_CLEAR];

   wire run         = ~halt_r & ~BREAK & ~STOP_MODE;

   wire pit_pkg::pit_count_t modulo = {mod_hi_r, mod_lo_r};

   wire wrap        = tick & (count_r == modulo);

   wire ovf_set     = wrap & ~mod_inhibit_r;

   wire flag_wr0    = wr_status & ~WDATA[`PIT_BIT_FLAG];

   wire flag_clr    = flag_wr0 & arm_r & ~brk_protect;

   pit_prescaler #(
      .PRE_W (`PIT_PRE_WIDTH)
   ) u_prescaler (
      .REF_CLK (REF_CLK),
      .NRST    (NRST),
      .run     (run),
      .clear   (cnt_clear),
      .sel     (ps_r),
      .tick    (tick)
   );

   assign flag_nxt = ovf_set | (flag_r & ~flag_clr);

   // New overflow disarms
   // A fresh overflow drops the arm so a stale read cannot clear an unseen event.
   assign arm_nxt = ovf_set                       ? 1'b0 :
                    (rd_status & flag_r & ~brk_protect) ? 1'b1 :
                    (wr_status & ~brk_protect)    ? 1'b0 :
                    arm_r;

   assign count_nxt = cnt_clear ? `PIT_RST_COUNT :
                      wrap      ? `PIT_RST_COUNT :
                      tick      ? pit_pkg::pit_count_t'(count_r + CNT_W'(1)) :
                      count_r;

   // Read data mux; the clear bit and bit 3 always read zero.
   always_comb begin
      rdata_nxt = rdata_r;
      if (RD) begin
         unique case (1'b1)
            sel_status: rdata_nxt = {flag_r, irq_en_r, halt_r, 2'b00, ps_r};
            sel_cnt_hi: rdata_nxt = count_r[15:8];
            sel_cnt_lo: rdata_nxt = latched_r ? low_latch_r : count_r[7:0];
            sel_mod_hi: rdata_nxt = mod_hi_r;
            sel_mod_lo: rdata_nxt = mod_lo_r;
            default:    rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         flag_r <= 1'b0;
         arm_r  <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
         arm_r  <= arm_nxt;
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         irq_en_r <= 1'b0;
         halt_r   <= `PIT_RST_HALT;
         ps_r     <= pit_pkg::pit_prescale_t'(`PIT_RST_PS);
      end else if (wr_status) begin
         irq_en_r <= WDATA[`PIT_BIT_IRQ_EN];
         halt_r   <= WDATA[`PIT_BIT_HALT];
         ps_r     <= pit_pkg::pit_prescale_t'(WDATA[`PIT_PS_MSB:`PIT_PS_LSB]);
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         count_r <= `PIT_RST_COUNT;
      end else begin
         count_r <= count_nxt;
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         mod_hi_r      <= 8'(`PIT_RST_MODULO >> 8);
         mod_lo_r      <= 8'(`PIT_RST_MODULO);
         mod_inhibit_r <= 1'b0;
      end else begin
         if (wr_mod_hi) begin
            mod_hi_r      <= WDATA;
            mod_inhibit_r <= 1'b1;
         end
         if (wr_mod_lo) begin
            mod_lo_r      <= WDATA;
            mod_inhibit_r <= 1'b0;
         end
      end
   end

   // Low byte buffer
   // The buffer is also cleared by a counter clear so a stale byte never outlives the count.
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         low_latch_r <= 8'h00;
         latched_r   <= 1'b0;
      end else if (cnt_clear) begin
         low_latch_r <= 8'h00;
         latched_r   <= 1'b0;
      end else if (rd_cnt_hi && !latched_r) begin
         low_latch_r <= count_r[7:0];
         latched_r   <= 1'b1;
      end else if (rd_cnt_lo) begin
         latched_r   <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign RDATA = rdata_r;

   assign IRQ = flag_r & irq_en_r & ~mod_inhibit_r;

   // Checks

   AST_BREAK_FREEZE: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      (BREAK && !cnt_clear) |=> (count_r == $past(count_r)))
      else $error("Counter moved during break.");

   AST_BREAK_PERMIT: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      (BREAK && BREAK_CLEAR_PERMIT && flag_r && arm_r && flag_wr0 && !ovf_set) |=> !flag_r)
      else $error("Permitted break clear did not clear the flag.");

   AST_BREAK_PROTECT: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      (brk_protect && flag_r) |=> flag_r)
      else $error("Flag changed under break protection.");

   AST_FLAG_SET: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      (tick && count_r == modulo && !mod_inhibit_r) |=> flag_r)
      else $error("Flag not set at modulo match.");

   AST_CLEAR_SEQ: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      (rd_status && flag_r && !BREAK && !ovf_set) ##1 (flag_wr0 && !BREAK && !ovf_set) |=> !flag_r)
      else $error("Read then zero write did not clear the flag.");

   AST_WRITE_ONE: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      (wr_status && WDATA[`PIT_BIT_FLAG] && flag_r) |=> flag_r)
      else $error("Writing one altered the flag.");

   AST_IRQ_GATE: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      (wr_status && !WDATA[`PIT_BIT_IRQ_EN]) |=> !IRQ)
      else $error("Request raised with enable clear.");

   AST_HALT: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      (halt_r && !cnt_clear) |=> $stable(count_r))
      else $error("Counter advanced while halted.");

   AST_CNT_CLEAR: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      cnt_clear |=> (count_r == 16'h0000) && !latched_r)
      else $error("Counter clear did not zero the count.");

   AST_HALT_CLEAR: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      (wr_status && WDATA[`PIT_BIT_HALT] && WDATA[`PIT_BIT_CLEAR]) |=> (halt_r && count_r == 16'h0000))
      else $error("Halt with clear did not stop at zero.");

   AST_LOW_LATCH: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      rd_cnt_lo |=> (RDATA == ($past(latched_r) ? $past(low_latch_r) : $past(count_r[7:0]))))
      else $error("Low byte read returned the wrong value.");

   AST_WRAP: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      (wrap && !cnt_clear) |=> (count_r == 16'h0000))
      else $error("Counter did not restart after modulo.");

   AST_INHIBIT: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      (mod_inhibit_r && !flag_r) |=> !flag_r)
      else $error("Flag set while modulo write pending.");

   AST_STEP: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      (tick && !wrap && !cnt_clear) |=> (count_r == 16'($past(count_r) + 16'h0001)))
      else $error("Counter did not step by one.");

   AST_STOP_IDLE: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      (STOP_MODE && !WR) |=> ($stable(count_r) && $stable(flag_r)))
      else $error("Timer changed in stop mode.");

   AST_IRQ_LEVEL: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      (IRQ && !flag_clr && !wr_status && !wr_mod_hi) |=> IRQ)
      else $error("Request dropped without a clear.");

   AST_LATE_OVERFLOW: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      (rd_status && flag_r && !brk_protect && !ovf_set) ##1 ovf_set ##1 flag_wr0 |=> flag_r)
      else $error("Zero write cleared a flag set after the status read.");

   AST_RESET_STATE: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      $rose(NRST) |-> (count_r == `PIT_RST_COUNT && modulo == `PIT_RST_MODULO &&
                       halt_r && !flag_r && !irq_en_r && ps_r == pit_pkg::PIT_DIV1))
      else $error("Register state after reset is wrong.");

   AST_HALT_RESUME: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      (!halt_r && !BREAK && !STOP_MODE && ps_r == pit_pkg::PIT_DIV1 && !wr_status) |-> tick)
      else $error("Counter clock missing with halt clear at full rate.");

   AST_PRESCALE_STEP: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      (tick && !wr_status && ps_r != pit_pkg::PIT_DIV1) |=> !tick)
      else $error("Divided counter clock ticked on two cycles in a row.");

   AST_CLEAR_READS_ZERO: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      rd_status |=> (RDATA[`PIT_BIT_CLEAR] == 1'b0))
      else $error("Counter clear bit read back as one.");

   AST_LATCH_HOLD: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      (rd_cnt_hi && latched_r) |=> (latched_r && low_latch_r == $past(low_latch_r)))
      else $error("Repeated high byte read changed the latched low byte.");

   AST_MOD_HI_WRITE: assert property (
      @(posedge REF_CLK) disable iff (!NRST)
      wr_mod_hi |=> (mod_inhibit_r && mod_hi_r == $past(WDATA)))
      else $error("Modulo high write did not arm the inhibit.");

endmodule

// >>> verification/pit_timer_tb_top.sv
// Self-checking bench for the periodic timer: register port tasks and directed sequences.
// Assumes the design's register map header and one REF_CLK domain driven by this bench.
`timescale 1ns/100ps
`include "pit_params.svh"

module pit_timer_tb_top;
   localparam logic [7:0] A_ST = `PIT_ADDR_STATUS;
   localparam logic [7:0] A_CH = `PIT_ADDR_CNT_HI;
   localparam logic [7:0] A_CL = `PIT_ADDR_CNT_LO;
   localparam logic [7:0] A_MH = `PIT_ADDR_MOD_HI;
   localparam logic [7:0] A_ML = `PIT_ADDR_MOD_LO;

   logic        ref_clk;
   logic        nrst;
   logic [7:0]  addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   logic        brk;
   logic        permit;
   logic        stop_mode;
   logic        irq;
   int          n_mismatch;
   int          n_checks;
   int          cyc = 0;
   int          dv;
   logic [7:0]  v;
   logic [7:0]  v0;
   logic [15:0] c16;
   logic [15:0] c2;

   pit_timer DUT (.REF_CLK(ref_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
                  .RDATA(rdata), .BREAK(brk), .BREAK_CLEAR_PERMIT(permit), .STOP_MODE(stop_mode),
                  .IRQ(irq));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // The limit covers the prescale sweep with a wide margin.
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr    <= 1'b0;
   endtask

   // Read data appear at the edge after the strobe and hold until the next read, so they are taken just after that edge.
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
      logic [7:0] d;
      rd_reg(a, d);
      chk(name, exp, d);
   endtask

   task automatic rd_cnt(output logic [15:0] c);
      rd_reg(A_CH, c[15:8]);
      rd_reg(A_CL, c[7:0]);
   endtask

   task automatic rst_chk();
      chk("irq_rst", 1'b0, irq);
      rd_chk(A_ST, 8'h20, "status_rst");
      rd_chk(A_MH, 8'hff, "mod_hi_rst");
      rd_chk(A_ML, 8'hff, "mod_lo_rst");
      rd_cnt(c16);
      chk("count_rst", 16'h0000, c16);
   endtask

   initial begin
      nrst      = 1'b0;
      addr      = 8'h00;
      wdata     = 8'h00;
      wr        = 1'b0;
      rd        = 1'b0;
      brk       = 1'b0;
      permit    = 1'b0;
      stop_mode = 1'b0;
      n_mismatch = 0;
      n_checks   = 0;
      repeat (3) @(posedge ref_clk);
      nrst <= 1'b1;
      rst_chk();
      rd_chk(8'h50, 8'h00, "unmapped");
      wr_reg(8'h50, 8'h5a);
      rd_chk(A_ST, 8'h20, "status_after_unmapped");
      for (int code = 0; code < 8; code++) begin
         wr_reg(A_ST, 8'h30 | 8'(code));
         rd_cnt(c16);
         chk("count_clear_halt", 16'h0000, c16);
         rd_chk(A_ST, 8'h20 | 8'(code), "status_ps");
         wr_reg(A_ST, 8'(code));
         repeat (256) @(posedge ref_clk);
         wr_reg(A_ST, 8'h20 | 8'(code));
         dv = 1 << ((code == 7) ? 6 : code);
         rd_cnt(c16);
         chk("count_div_in_range", 1'b1, (c16 >= 16'(258 / dv - 1)) && (c16 <= 16'(258 / dv + 1)));
         rd_cnt(c2);
         chk("count_halted", c16, c2);
      end
      wr_reg(A_ST, 8'h30);
      wr_reg(A_ST, 8'h00);
      repeat (10) @(posedge ref_clk);
      rd_reg(A_CL, v0);
      rd_reg(A_CH, v);
      repeat (20) @(posedge ref_clk);
      rd_reg(A_CH, v);
      rd_chk(A_CL, v0 + 8'h02, "latched_lo");
      rd_chk(A_CL, v0 + 8'h1c, "live_lo");
      for (int k = 0; k < 2; k++) begin
         @(posedge ref_clk);
         brk       <= (k == 0);
         stop_mode <= (k == 1);
         repeat (2) @(posedge ref_clk);
         rd_reg(A_CH, v);
         rd_reg(A_CL, v0);
         repeat (20) @(posedge ref_clk);
         rd_chk(A_CL, v0, "frozen_lo");
         @(posedge ref_clk);
         brk       <= 1'b0;
         stop_mode <= 1'b0;
         repeat (3) @(posedge ref_clk);
         rd_reg(A_CL, v);
         chk("resumed", 1'b1, v !== v0);
      end
      // Clearing the counter first keeps it below the new modulo.
      wr_reg(A_ST, 8'h30);
      wr_reg(A_MH, 8'h00);
      wr_reg(A_ST, 8'h40);
      repeat (300) @(posedge ref_clk);
      rd_chk(A_ST, 8'h40, "status_inhibit");
      chk("irq_inhibit", 1'b0, irq);
      wr_reg(A_ML, 8'h04);
      wr_reg(A_ST, 8'h50);
      repeat (12) @(posedge ref_clk);
      rd_reg(A_ST, v);
      chk("flag_set", 1'b1, v[7]);
      chk("irq_set", 1'b1, irq);
      wr_reg(A_ST, 8'hc0);
      rd_reg(A_ST, v);
      chk("flag_write_one", 1'b1, v[7]);
      wr_reg(A_ST, 8'h00);
      #1;
      chk("irq_masked", 1'b0, irq);
      wr_reg(A_ST, 8'h40);
      for (int i = 0; i < 8; i++) begin
         rd_cnt(c16);
         chk("count_wraps", 1'b1, c16 <= 16'h0004);
      end
      rd_reg(A_ST, v);
      repeat (10) @(posedge ref_clk);
      wr_reg(A_ST, 8'h40);
      #1;
      chk("irq_after_late_clear", 1'b1, irq);
      wr_reg(A_ST, 8'h60);
      rd_chk(A_ST, 8'he0, "status_halt_flag");
      wr_reg(A_ST, 8'h60);
      #1;
      chk("irq_cleared", 1'b0, irq);
      rd_chk(A_ST, 8'h60, "flag_cleared");
      for (int p = 0; p < 2; p++) begin
         wr_reg(A_ST, 8'h40);
         repeat (12) @(posedge ref_clk);
         wr_reg(A_ST, 8'h60);
         if (p == 0) begin
            rd_reg(A_ST, v);
         end
         @(posedge ref_clk);
         brk    <= 1'b1;
         permit <= (p == 1);
         rd_reg(A_ST, v);
         wr_reg(A_ST, 8'h60);
         rd_chk(A_ST, (p == 1) ? 8'h60 : 8'he0, "status_in_break");
         @(posedge ref_clk);
         brk    <= 1'b0;
         permit <= 1'b0;
         if (p == 0) begin
            wr_reg(A_ST, 8'h60);
         end
         rd_chk(A_ST, 8'h60, "status_after_break");
      end
      wr_reg(A_ST, 8'h40);
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      rst_chk();
      stop_test();
   end
endmodule
